/* File: logic/dcsp_pkg.sv */
// Constants, states and frame check arithmetic for the daisy chain serial port.
// Assumes a 40 MHz system clock; all pin timing is sampled against it.
package dcsp_pkg;

  // System clock period and derived poll toggle timing
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned TOGGLE_HALF_US  = 500;          // Half period of the 1 kHz poll toggle
  localparam int unsigned HALF_MS_CYCLES  = (TOGGLE_HALF_US * 1000) / CLK_PERIOD_NS;

  // Watchdog: expiry anywhere in 1 s .. 2.5 s is legal, 1.5 s is chosen
  localparam int unsigned WDT_TIMEOUT_MS  = 1500;
  localparam int unsigned WDT_HALF_TICKS  = WDT_TIMEOUT_MS * 2;
  localparam logic [11:0] WDT_LIMIT       = 12'(WDT_HALF_TICKS);

  // Frame check byte
  localparam logic [7:0]  CRC_INIT        = 8'h41;

  // Frame layout: six configuration bytes then the check byte
  localparam int unsigned CFG_BITS        = 48;
  localparam int unsigned BLOCK_BITS      = 56;
  localparam logic [5:0]  BLOCK_LEN       = 6'h38;
  localparam logic [3:0]  CMD_LAST_BIT    = 4'hf;
  localparam logic [3:0]  CMD_BYTE_BITS   = 4'h8;

  // Field positions inside the configuration word, first byte at the top
  localparam int unsigned CFG_CDC_LSB     = 40;
  localparam int unsigned CFG_LEVEL_POLL_SELECT_BIT   = 43;
  localparam int unsigned CFG_WDT_BIT     = 47;
  localparam logic [47:0] CFG_DEFAULT     = 48'h0000_0000_0000;

  // Command codes
  localparam logic [7:0]  CMD_WRITE_CFG   = 8'h01;
  localparam logic [7:0]  CMD_READ_CFG    = 8'h02;
  localparam logic [7:0]  CMD_CELL_CONV   = 8'h10;
  localparam logic [7:0]  CMD_POLL_CONV   = 8'h40;
  localparam logic [7:0]  CMD_POLL_ALARM  = 8'h50;

  // Link states
  typedef enum logic [4:0] {
    DCSP_IDLE  = 5'b00001,
    DCSP_CMD   = 5'b00010,
    DCSP_WRITE = 5'b00100,
    DCSP_READ  = 5'b01000,
    DCSP_POLL  = 5'b10000
  } dcsp_state_e;

  // One frame check step: feedback into bits 0..2, the rest shift up
  function automatic logic [7:0] dcsp_crc_step(input logic [7:0] crc, input logic din);
    logic fb;
    fb = din ^ crc[7];
    return {crc[6:2], crc[1] ^ fb, crc[0] ^ fb, fb};
  endfunction

  // Frame check over a whole configuration block, first byte first
  function automatic logic [7:0] dcsp_crc_block(input logic [47:0] data);
    logic [7:0] crc;
    crc = CRC_INIT;
    for (int i = CFG_BITS - 1; i >= 0; i--) begin
      crc = dcsp_crc_step(crc, data[i]);
    end
    return crc;
  endfunction

endpackage

/* File: logic/dcsp_crc8.sv */
// Serial frame check engine used on the command byte.
// Assumes init and step come from logic on the same clock, never together.
`timescale 1ns/1ps
module dcsp_crc8
  import dcsp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  // Control
  input  wire logic       init_i,
  input  wire logic       step_i,
  input  wire logic       bit_i,
  // Result
  output logic [7:0]      crc_o
);

  logic [7:0] crc_q;
  logic [7:0] crc_d;

  // Next check value
  always_comb begin
    crc_d = crc_q;
    if (init_i) begin
      crc_d = CRC_INIT;
    end else if (step_i) begin
      crc_d = dcsp_crc_step(crc_q, bit_i);
    end
  end

  // Check register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crc_q <= CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc_o = crc_q;

endmodule

/* File: logic/dcsp_port.sv */
// Stackable serial port: command check, chained read/write, polling, watchdog.
// Assumes pins arrive asynchronously; busy and alarm come from same-clock logic.
//
// How it works
// - Watchdog runs except while comparator duty cycle is zero.
// - Watchdog expires after 1 to 2.5 s without a valid command.
// - Expiry drives watchdog pin low and restores power-up configuration.
// - Watchdog pin stays low until the next valid command.
// - Outside pull-down never fires watchdog; first config byte bit 7 reads pin.
// - Data sampled on rising clock, read data launched on falling clock.
// - Bytes are eight bits, most significant bit first.
// - Written data commits only at chain select rising edge.
// - Check byte is CRC-8, polynomial x8+x2+x+1, start value 0x41.
// - Feedback is bit xor check bit 7, into bits 0..2; rest shift up.
// - Commands and data act only when their check byte matches.
// - Read data is followed by the device's own check byte.
// - Chained read: own block first, then blocks from devices above.
// - All devices take the command together, then form one shift register; command bits are not relayed upward, high-side data drives only in writes.
// - Low-side pin: input on writes, output on reads unless bottom.
// - Open-drain return line is driven only on the bottom device.
// - Strap high means voltage-mode low side, low means current mode.
// - Top strap makes the device generate the idle poll pattern.
// - Select held low after convert shows converter status on return line.
// - Separate poll commands exist for converter busy and for alarms.
// - Poll: low when busy/alarmed, else 1 kHz toggle or steady high.
// - Idle non-top device passes the level from above downward.
`timescale 1ns/1ps
module dcsp_port
  import dcsp_pkg::*;
#(
  parameter int unsigned HALF_MS_CLKS = HALF_MS_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Low-side port
  input  wire logic        chain_select_in_i,
  input  wire logic        chain_clock_in_i,
  input  wire logic        low_side_data_in_i,
  output logic             low_side_data_out_o,
  output logic             low_side_data_oe_o,
  output logic             bottom_return_data_od_out_o,
  output logic             bottom_return_data_od_oe_o,
  // High-side port
  output logic             chain_select_out_o,
  output logic             chain_clock_out_o,
  input  wire logic        high_side_data_in_i,
  output logic             high_side_data_out_o,
  output logic             high_side_data_oe_o,
  // Straps
  input  wire logic        port_signalling_select_i,
  input  wire logic        stack_top_strap_i,
  output logic             low_side_current_mode_o,
  // Watchdog pin
  input  wire logic        watchdog_out_n_in_i,
  output logic             watchdog_out_n_out_o,
  output logic             watchdog_out_n_oe_o,
  // Converter and alarm status
  input  wire logic        conv_busy_i,
  input  wire logic        alarm_i,
  output logic             cell_convert_start_o,
  // Configuration
  output logic [47:0]      config_o,
  output logic [2:0]       comparator_duty_cycle_o
);

  // Pin synchronisers: stage 1 feeds stage 2 only, stage 3 is for edges and the relayed select and clock
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [1:0] sync3_q;
  logic       cs_s;
  logic       sck_s;
  logic       sdi_s;
  logic       hsi_s;
  logic       bottom_s;
  logic       top_s;
  logic       wdt_pin_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       cs_fall;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_q <= 7'h7f;
      sync2_q <= 7'h7f;
      sync3_q <= 2'h3;
    end else begin
      sync1_q <= {watchdog_out_n_in_i, stack_top_strap_i, port_signalling_select_i,
                  high_side_data_in_i, low_side_data_in_i, chain_clock_in_i,
                  chain_select_in_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q[1:0];
    end
  end

  assign cs_s      = sync2_q[0];
  assign sck_s     = sync2_q[1];
  assign sdi_s     = sync2_q[2];
  assign hsi_s     = sync2_q[3];
  assign bottom_s  = sync2_q[4];
  assign top_s     = sync2_q[5];
  assign wdt_pin_s = sync2_q[6];
  assign sck_rise  = sck_s & ~sync3_q[1];
  assign sck_fall  = ~sck_s & sync3_q[1];
  assign cs_rise   = cs_s & ~sync3_q[0];
  assign cs_fall   = ~cs_s & sync3_q[0];

  // Half-millisecond divider, poll toggle and watchdog
  logic [15:0] div_q;
  logic [15:0] div_d;
  logic        tog_q;
  logic        tog_d;
  logic [11:0] wdt_cnt_q;
  logic [11:0] wdt_cnt_d;
  logic        expired_q;
  logic        expired_d;
  logic        half_ms;
  logic        wdt_fire;
  logic        cmd_ok;
  logic [47:0] cfg_q;

  always_comb begin
    half_ms   = (div_q == 16'(HALF_MS_CLKS - 1));
    div_d     = half_ms ? 16'h0000 : div_q + 16'h0001;
    tog_d     = half_ms ? ~tog_q : tog_q;
    wdt_fire  = 1'b0;
    wdt_cnt_d = wdt_cnt_q;
    expired_d = expired_q;
    if (cmd_ok) begin
      wdt_cnt_d = 12'h000;
      expired_d = 1'b0;
    end else if (cfg_q[CFG_CDC_LSB +: 3] == 3'h0) begin
      wdt_cnt_d = 12'h000;
    end else if (half_ms) begin
      if (wdt_cnt_q == WDT_LIMIT - 12'h001) begin
        wdt_fire  = 1'b1;
        wdt_cnt_d = 12'h000;
        expired_d = 1'b1;
      end else begin
        wdt_cnt_d = wdt_cnt_q + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q     <= 16'h0000;
      tog_q     <= 1'b0;
      wdt_cnt_q <= 12'h000;
      expired_q <= 1'b0;
    end else begin
      div_q     <= div_d;
      tog_q     <= tog_d;
      wdt_cnt_q <= wdt_cnt_d;
      expired_q <= expired_d;
    end
  end

  // Link state
  dcsp_state_e state_q;
  dcsp_state_e state_d;
  logic [3:0]  cmd_cnt_q;
  logic [3:0]  cmd_cnt_d;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic [7:0]  pec_q;
  logic [7:0]  pec_d;
  logic [5:0]  blk_cnt_q;
  logic [5:0]  blk_cnt_d;
  logic [55:0] shreg_q;
  logic [55:0] shreg_d;
  logic        hs_out_q;
  logic        hs_out_d;
  logic        out_bit_q;
  logic        out_bit_d;
  logic        poll_alarm_q;
  logic        poll_alarm_d;
  logic        conv_q;
  logic        conv_d;
  logic [47:0] cfg_d;
  logic [47:0] cfg_rd;
  logic [7:0]  crc_cmd;
  logic        crc_init;
  logic        crc_step;
  logic [7:0]  pec_rx;
  logic        own_flag;
  logic        poll_level;

  // Command check engine
  dcsp_crc8 u_cmd_crc (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .init_i    (crc_init),
    .step_i    (crc_step),
    .bit_i     (sdi_s),
    .crc_o     (crc_cmd)
  );

  // Read image: bit 7 of the first byte follows the watchdog pin
  always_comb begin
    cfg_rd              = cfg_q;
    cfg_rd[CFG_WDT_BIT] = wdt_pin_s;
  end

  always_comb begin
    state_d      = state_q;
    cmd_cnt_d    = cmd_cnt_q;
    cmd_d        = cmd_q;
    pec_d        = pec_q;
    blk_cnt_d    = blk_cnt_q;
    shreg_d      = shreg_q;
    hs_out_d     = hs_out_q;
    out_bit_d    = out_bit_q;
    poll_alarm_d = poll_alarm_q;
    conv_d       = 1'b0;
    cfg_d        = cfg_q;
    cmd_ok       = 1'b0;
    crc_init     = 1'b0;
    crc_step     = 1'b0;
    pec_rx       = {pec_q[6:0], sdi_s};
    // Poll answer: own flag pulls low, else top makes the pattern, else pass down
    own_flag     = poll_alarm_q ? alarm_i : conv_busy_i;
    if (own_flag) begin
      poll_level = 1'b0;
    end else if (top_s) begin
      poll_level = cfg_q[CFG_LEVEL_POLL_SELECT_BIT] ? 1'b1 : tog_q;
    end else begin
      poll_level = hsi_s;
    end
    if (cs_rise) begin
      // Commit a written block only if it is whole and its check matches
      if (state_q == DCSP_WRITE && blk_cnt_q == BLOCK_LEN &&
          dcsp_crc_block(shreg_q[55:8]) == shreg_q[7:0]) begin
        cfg_d = shreg_q[55:8];
      end
      state_d = DCSP_IDLE;
    end else if (cs_fall) begin
      state_d   = DCSP_CMD;
      cmd_cnt_d = 4'h0;
      crc_init  = 1'b1;
    end else begin
      unique case (state_q)
        DCSP_IDLE: begin
        end
        DCSP_CMD: begin
          if (sck_rise) begin
            cmd_cnt_d = cmd_cnt_q + 4'h1;
            if (cmd_cnt_q < CMD_BYTE_BITS) begin
              cmd_d    = {cmd_q[6:0], sdi_s};
              crc_step = 1'b1;
            end else begin
              pec_d = pec_rx;
            end
            if (cmd_cnt_q == CMD_LAST_BIT) begin
              state_d   = DCSP_IDLE;
              blk_cnt_d = 6'h00;
              if (pec_rx == crc_cmd) begin
                cmd_ok = 1'b1;
                unique case (cmd_q)
                  CMD_WRITE_CFG: begin
                    state_d = DCSP_WRITE;
                    shreg_d = '0;
                  end
                  CMD_READ_CFG: begin
                    state_d = DCSP_READ;
                    shreg_d = {cfg_rd, dcsp_crc_block(cfg_rd)};
                  end
                  CMD_CELL_CONV: begin
                    conv_d       = 1'b1;
                    state_d      = DCSP_POLL;
                    poll_alarm_d = 1'b0;
                  end
                  CMD_POLL_CONV: begin
                    state_d      = DCSP_POLL;
                    poll_alarm_d = 1'b0;
                  end
                  CMD_POLL_ALARM: begin
                    state_d      = DCSP_POLL;
                    poll_alarm_d = 1'b1;
                  end
                  default: begin
                  end
                endcase
              end
            end
          end
        end
        DCSP_WRITE: begin
          // Keep the last block; older bits move on to the device above
          if (sck_rise) begin
            shreg_d = {shreg_q[54:0], sdi_s};
            if (blk_cnt_q != BLOCK_LEN) begin
              blk_cnt_d = blk_cnt_q + 6'h01;
            end
          end
          // Oldest held bit goes up now, so the upper device samples it next rise
          if (sck_fall) begin
            hs_out_d = shreg_q[55];
          end
        end
        DCSP_READ: begin
          // Own block leaves first, then whatever arrives from above
          // Bit from above enters at the rise, so it leaves 56 bits later
          if (sck_rise) begin
            shreg_d = {shreg_q[54:0], hsi_s};
          end
          if (sck_fall) begin
            out_bit_d = shreg_q[55];
          end
        end
        DCSP_POLL: begin
          out_bit_d = poll_level;
        end
        default: begin
          state_d = DCSP_IDLE;
        end
      endcase
    end
    if (wdt_fire) begin
      cfg_d = CFG_DEFAULT;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q      <= DCSP_IDLE;
      cmd_cnt_q    <= 4'h0;
      cmd_q        <= 8'h00;
      pec_q        <= 8'h00;
      blk_cnt_q    <= 6'h00;
      shreg_q      <= '0;
      hs_out_q     <= 1'b1;
      out_bit_q    <= 1'b1;
      poll_alarm_q <= 1'b0;
      conv_q       <= 1'b0;
      cfg_q        <= CFG_DEFAULT;
    end else begin
      state_q      <= state_d;
      cmd_cnt_q    <= cmd_cnt_d;
      cmd_q        <= cmd_d;
      pec_q        <= pec_d;
      blk_cnt_q    <= blk_cnt_d;
      shreg_q      <= shreg_d;
      hs_out_q     <= hs_out_d;
      out_bit_q    <= out_bit_d;
      poll_alarm_q <= poll_alarm_d;
      conv_q       <= conv_d;
      cfg_q        <= cfg_d;
    end
  end

  // Chain select and clock relayed upward from the synchronised copies
  assign chain_select_out_o = sync3_q[0];
  assign chain_clock_out_o  = sync3_q[1];

  // Pin directions follow the transfer in progress and the bottom strap
  logic talking;
  assign talking                     = (state_q == DCSP_READ) || (state_q == DCSP_POLL);
  assign low_side_data_out_o         = out_bit_q;
  assign low_side_data_oe_o          = talking & ~bottom_s;
  assign bottom_return_data_od_out_o = 1'b0;
  assign bottom_return_data_od_oe_o  = talking & bottom_s & ~out_bit_q;
  assign high_side_data_out_o        = hs_out_q;
  assign high_side_data_oe_o         = (state_q == DCSP_WRITE);
  assign low_side_current_mode_o     = ~bottom_s;

  // Watchdog pin pulls low while expired
  assign watchdog_out_n_out_o = 1'b0;
  assign watchdog_out_n_oe_o  = expired_q;

  // Status and configuration
  assign cell_convert_start_o    = conv_q;
  assign config_o                = cfg_q;
  assign comparator_duty_cycle_o = cfg_q[CFG_CDC_LSB +: 3];

endmodule

/* File: verif/dcsp_port_chk.sv */
// Checker for the daisy chain serial port, bound to its top-level ports.
// Assumes pins hold steady for at least three system clocks between changes.
`timescale 1ns/1ps
module dcsp_port_chk
  import dcsp_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  // Pins and straps
  input wire logic        chain_select_in_i,
  input wire logic        chain_select_out_o,
  input wire logic        port_signalling_select_i,
  input wire logic        low_side_current_mode_o,
  input wire logic        low_side_data_oe_o,
  input wire logic        high_side_data_oe_o,
  input wire logic        bottom_return_data_od_out_o,
  input wire logic        bottom_return_data_od_oe_o,
  // Status
  input wire logic        watchdog_out_n_oe_o,
  input wire logic        cell_convert_start_o,
  input wire logic [47:0] config_o,
  input wire logic [2:0]  comparator_duty_cycle_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  // Select seen high long enough for any frame to have closed
  sequence s_sel_idle;
    chain_select_in_i [*6];
  endsequence
  // Start strobe falls back and stays quiet
  sequence s_start_quiet;
    !cell_convert_start_o [*2];
  endsequence

  property p_cdc_field;
    comparator_duty_cycle_o == config_o[42:40];
  endproperty
  a_cdc_field: assert property (p_cdc_field) else $error("duty cycle field mismatch");
  property p_od_drive;
    bottom_return_data_od_oe_o |-> !low_side_data_oe_o && !low_side_current_mode_o
      && bottom_return_data_od_out_o == 1'b0;
  endproperty
  a_od_drive: assert property (p_od_drive) else $error("return line misuse");
  property p_low_dir;
    low_side_data_oe_o |-> low_side_current_mode_o && !high_side_data_oe_o;
  endproperty
  a_low_dir: assert property (p_low_dir) else $error("low side direction wrong");
  property p_idle_quiet;
    s_sel_idle |-> !low_side_data_oe_o && !high_side_data_oe_o && !bottom_return_data_od_oe_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("driving while deselected");
  property p_commit;
    $changed(config_o) && config_o != CFG_DEFAULT |-> $past(chain_select_in_i, 2);
  endproperty
  a_commit: assert property (p_commit) else $error("config changed inside frame");
  property p_wdt_cfg;
    $rose(watchdog_out_n_oe_o) |-> ##[0:2] config_o == CFG_DEFAULT;
  endproperty
  a_wdt_cfg: assert property (p_wdt_cfg) else $error("expiry kept config");
  property p_wdt_run;
    $rose(watchdog_out_n_oe_o) |-> $past(comparator_duty_cycle_o, 2) != 3'h0;
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog fired in standby");
  property p_wdt_release;
    $fell(watchdog_out_n_oe_o) |-> !$past(chain_select_in_i, 2);
  endproperty
  a_wdt_release: assert property (p_wdt_release) else $error("watchdog released idle");
  property p_start;
    cell_convert_start_o |-> !$past(chain_select_in_i, 2) ##1 s_start_quiet;
  endproperty
  a_start: assert property (p_start) else $error("bad convert strobe");
  property p_sel_relay;
    chain_select_out_o == $past(chain_select_in_i, 3);
  endproperty
  a_sel_relay: assert property (p_sel_relay) else $error("select relay wrong");
  property p_mode;
    $stable(port_signalling_select_i) [*4] |->
      low_side_current_mode_o == !port_signalling_select_i;
  endproperty
  a_mode: assert property (p_mode) else $error("signalling mode wrong");
endmodule

bind dcsp_port dcsp_port_chk u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .chain_select_in_i(chain_select_in_i),
  .chain_select_out_o(chain_select_out_o), .port_signalling_select_i(port_signalling_select_i),
  .low_side_current_mode_o(low_side_current_mode_o), .low_side_data_oe_o(low_side_data_oe_o),
  .high_side_data_oe_o(high_side_data_oe_o),
  .bottom_return_data_od_out_o(bottom_return_data_od_out_o),
  .bottom_return_data_od_oe_o(bottom_return_data_od_oe_o),
  .watchdog_out_n_oe_o(watchdog_out_n_oe_o), .cell_convert_start_o(cell_convert_start_o),
  .config_o(config_o), .comparator_duty_cycle_o(comparator_duty_cycle_o)
);

/* File: verif/dcsp_upper_model.sv */
// Model of the next higher stacked device, seen from our high-side port.
// Assumes its clock and select are our relayed outputs.
`timescale 1ns/1ps
module dcsp_upper_model #(
  parameter logic [63:0] PATTERN = 64'ha55a_3cc3_0ff0_9669
) (
  // Relayed link from below
  input  wire logic        sel_n_i,
  input  wire logic        sck_i,
  input  wire logic        sdi_i,
  input  wire logic        sdi_oe_i,
  // Status and data toward below
  input  wire logic        busy_i,
  output logic             sdo_o,
  output logic [55:0]      rx_o
);
  logic [63:0] pat_q = PATTERN;
  logic [4:0]  fall_q = 5'h0;
  logic        idle_q = 1'b0;
  logic        cur;

  // Busy pulls low, else our data or level goes down; released line inverts
  assign cur = busy_i ? 1'b0 : pat_q[63];
  assign sdo_o = sel_n_i ? idle_q : cur;

  // Read data launched on falling clock after the 16 command bits
  always @(posedge sel_n_i or negedge sck_i) begin
    if (sel_n_i) begin
      idle_q = ~cur;
      pat_q = PATTERN;
      fall_q = 5'h0;
    end else begin
      if (fall_q >= 5'd17) pat_q = pat_q << 1;
      if (fall_q < 5'd17) fall_q = fall_q + 5'd1;
    end
  end

  // Write data taken on rising clock, keeping the last block
  always @(posedge sck_i) begin
    if (!sel_n_i && sdi_oe_i) rx_o <= {rx_o[54:0], sdi_i};
  end
endmodule

/* File: verif/dcsp_port_tb.sv */
// Self-checking bench for the daisy chain serial port with an upper neighbour.
// Assumes the watchdog half-ms tick is shortened to four system clocks.
`timescale 1ns/1ps
module dcsp_port_tb
  import dcsp_pkg::*;
;
  localparam logic [63:0] PAT = 64'ha55a_3cc3_0ff0_9669;
  logic clk_sys_i = 0, resetn_i = 0, sel_n = 1, sck = 1, low_side_data_io = 1, strap_v = 1, top = 0;
  logic ext_wd_n = 1, conv_busy = 0, alarm = 0, up_busy = 0;
  logic lo_out, lo_oe, od_oe, cs_out, ck_out, hi_in, hi_out, hi_oe, wd_oe, start;
  logic [47:0] cfg, cur_cfg = 48'h0;
  logic [55:0] up_rx;
  logic wdt_pin, ret;
  int mismatches = 0, cmp_count = 0, starts = 0;

  // Pulled-up wires seen by every party
  assign wdt_pin = wd_oe ? 1'b0 : ext_wd_n;
  assign ret = strap_v ? !od_oe : (lo_oe ? lo_out : 1'bx);

  dcsp_port #(.HALF_MS_CLKS(4)) dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .chain_select_in_i(sel_n),
    .chain_clock_in_i(sck), .low_side_data_in_i(low_side_data_io), .low_side_data_out_o(lo_out),
    .low_side_data_oe_o(lo_oe), .bottom_return_data_od_out_o(),
    .bottom_return_data_od_oe_o(od_oe), .chain_select_out_o(cs_out),
    .chain_clock_out_o(ck_out), .high_side_data_in_i(hi_in), .high_side_data_out_o(hi_out),
    .high_side_data_oe_o(hi_oe), .port_signalling_select_i(strap_v),
    .stack_top_strap_i(top), .low_side_current_mode_o(), .watchdog_out_n_in_i(wdt_pin),
    .watchdog_out_n_out_o(), .watchdog_out_n_oe_o(wd_oe), .conv_busy_i(conv_busy),
    .alarm_i(alarm), .cell_convert_start_o(start), .config_o(cfg),
    .comparator_duty_cycle_o()
  );
  dcsp_upper_model #(.PATTERN(PAT)) up (
    .sel_n_i(cs_out), .sck_i(ck_out), .sdi_i(hi_out), .sdi_oe_i(hi_oe),
    .busy_i(up_busy), .sdo_o(hi_in), .rx_o(up_rx)
  );

  // Clock and convert strobe count
  always #12.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (start === 1'b1) starts++;

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask
  // Check byte worked out bit by bit, first bit first
  function automatic logic [7:0] crc(input logic [127:0] v, input int n);
    logic [7:0] c;
    logic fb;
    c = 8'h41;
    for (int i = n - 1; i >= 0; i--) begin
      fb = v[i] ^ c[7];
      c = {c[6:2], c[1] ^ fb, c[0] ^ fb, fb};
    end
    return c;
  endfunction
  // Shift bits out, sampling the return line just before each rise
  task automatic shift(input logic [127:0] v, input int n, output logic [127:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      low_side_data_io = v[i];
      cyc(4);
      r[i] = ret;
      sck = 1'b1;
      cyc(4);
    end
  endtask
  task automatic sel_hi;
    cyc(2);
    sel_n = 1'b1;
    cyc(12);
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] bad, input logic [127:0] d,
                       input int n, input bit keep, output logic [127:0] r);
    sel_n = 1'b0;
    cyc(4);
    shift({cmd, crc(cmd, 8) ^ bad}, 16, r);
    if (n > 0) shift(d, n, r);
    if (!keep) sel_hi();
  endtask

  task automatic t_write(input logic [47:0] u, input logic [47:0] own);
    logic [127:0] r;
    frame(CMD_WRITE_CFG, 8'h0, {u, crc(u, 48), own, crc(own, 48)}, 112, 1'b1, r);
    chk({hi_oe, lo_oe, od_oe}, 3'b100, "write direction");
    chk(cfg, cur_cfg, "commit before select rise");
    sel_hi();
    cur_cfg = own;
    chk(cfg, own, "own block commit");
    chk(up_rx, {u, crc(u, 48)}, "upper block relay");
  endtask
  task automatic t_read(input logic vm, input logic pull);
    logic [127:0] r;
    logic [47:0] own;
    strap_v = vm;
    ext_wd_n = pull;
    cyc(4);
    own = {pull, cur_cfg[46:0]};
    frame(CMD_READ_CFG, 8'h0, '0, 72, 1'b0, r);
    chk(r[71:0], {own, crc(own, 48), PAT[63:48]}, "read stream");
    chk({wd_oe, cfg}, {1'b0, cur_cfg}, "outside pull no event");
    strap_v = 1'b1;
    ext_wd_n = 1'b1;
  endtask
  task automatic t_poll;
    logic [7:0] cmds [3] = '{CMD_CELL_CONV, CMD_POLL_CONV, CMD_POLL_ALARM};
    logic [127:0] r;
    int s0;
    for (int i = 0; i < 3; i++) begin
      s0 = starts;
      frame(cmds[i], 8'h0, '0, 0, 1'b1, r);
      {conv_busy, alarm} = (i == 2) ? 2'b10 : 2'b01;
      cyc(6);
      chk(ret, 1'b1, "level from above");
      {conv_busy, alarm} = (i == 2) ? 2'b01 : 2'b10;
      cyc(6);
      chk(ret, 1'b0, "own flag low");
      {conv_busy, alarm, up_busy} = 3'b001;
      cyc(6);
      chk(ret, 1'b0, "upper flag low");
      {up_busy, top} = 2'b01;
      cyc(6);
      chk(ret, 1'b1, "top holds level");
      sel_hi();
      top = 1'b0;
      chk(starts - s0, i == 0, "convert strobe");
    end
  endtask
  task automatic t_toggle;
    logic [127:0] r;
    logic prev;
    int n;
    t_write(48'h0, 48'h01_00_00_00_00_00);
    top = 1'b1;
    frame(CMD_POLL_CONV, 8'h0, '0, 0, 1'b1, r);
    cyc(6);
    prev = ret;
    n = 0;
    repeat (40) begin
      cyc(1);
      if (ret !== prev) n++;
      prev = ret;
    end
    chk(n inside {[9:11]}, 1'b1, "toggle rate");
    sel_hi();
    top = 1'b0;
  endtask
  task automatic t_wdt;
    logic [127:0] r;
    cyc(7000);
    chk(wd_oe, 1'b0, "early expiry");
    for (int k = 0; k < 14000 && wd_oe !== 1'b1; k++) cyc(1);
    chk({wdt_pin, cfg}, {1'b0, 48'h0}, "expiry state");
    cyc(100);
    chk(wd_oe, 1'b1, "pin held low");
    frame(CMD_READ_CFG, 8'h0, '0, 0, 1'b0, r);
    chk(wd_oe, 1'b0, "released by command");
    cyc(21000);
    chk(wd_oe, 1'b0, "standby no watchdog");
  endtask

  // Timeout guard
  initial begin
    repeat (70000) @(posedge clk_sys_i);
    mismatches++;
    conclude();
  end
  // Main sequence
  initial begin
    logic [127:0] r;
    int s0;
    cyc(4);
    resetn_i = 1'b1;
    cyc(4);
    chk({cfg, lo_oe, hi_oe, od_oe, wd_oe}, '0, "reset state");
    t_write(48'h5a_11_22_33_44_55, 48'h09_12_34_56_78_9a);
    frame(CMD_WRITE_CFG, 8'h0, {48'h0f_ff_ff_ff_ff_ff, 8'h00}, 56, 1'b0, r);
    chk(cfg, cur_cfg, "bad block refused");
    t_read(1'b1, 1'b1);
    t_read(1'b0, 1'b0);
    s0 = starts;
    frame(CMD_CELL_CONV, 8'h01, '0, 0, 1'b1, r);
    cyc(6);
    chk({starts - s0, od_oe}, '0, "bad command refused");
    sel_hi();
    t_poll();
    t_toggle();
    t_wdt();
    conclude();
  end
endmodule
